// ===== rtl/pcr_top.sv
// Clock receiver and PLL configuration register block with APB access
`timescale 1ns/1ns
`include "pcr_params.svh"
module pcr_top
  import pcr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Analog PLL status
  input wire logic pll_locked_in,
  input wire logic [3:0] vco_ctrl_voltage_in,
  input wire logic [5:0] auto_band_in,
  // Clock receiver controls
  output logic conv_duty_corr_out,
  output logic ref_duty_corr_out,
  output logic conv_cross_corr_out,
  output logic ref_cross_corr_out,
  // PLL controls
  output logic pll_on_out,
  output logic manual_band_en_out,
  output logic [5:0] vco_band_out,
  output logic [1:0] loop_bw_out,
  output logic [4:0] charge_pump_out,
  output logic [4:0] controller_clock_ratio_out,
  output logic xpt_ctrl_en_out,
  output logic [2:0] vco_post_ratio_out,
  output logic [4:0] loop_ratio_out,
  // Interrupt
  output logic irq_out
);

  // ************************************************************
  // Decode helpers
  // ************************************************************

  // Controller divider code to ratio
  function automatic logic [4:0] ctl_ratio(input logic [1:0] code);
    case (code)
      2'b10: ctl_ratio = 5'h08;
      2'b11: ctl_ratio = 5'h10;
      default: ctl_ratio = 5'h02;
    endcase
  endfunction

  // Loop divider code to ratio, a power of two starting at 2
  function automatic logic [4:0] loop_ratio(input logic [1:0] code);
    case (code)
      2'b00: loop_ratio = 5'h02;
      2'b01: loop_ratio = 5'h04;
      2'b10: loop_ratio = 5'h08;
      default: loop_ratio = 5'h10;
    endcase
  endfunction

  // VCO post divider code to ratio; top two codes alias to 4
  function automatic logic [2:0] post_ratio(input logic [1:0] code);
    case (code)
      2'b00: post_ratio = 3'h1;
      2'b01: post_ratio = 3'h2;
      default: post_ratio = 3'h4;
    endcase
  endfunction

  // ************************************************************
  // Bus front end
  // ************************************************************
  logic wr_stb;
  logic rd_stb;
  logic hit;
  pcr_evt_if evt_bus();

  pcr_apb_slave u_apb
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .wr_stb_out(wr_stb),
    .rd_stb_out(rd_stb),
    .pready_out(pready_out)
  );

  pcr_lock_watch u_watch
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pll_locked_in(pll_locked_in),
    .evt(evt_bus)
  );

  // ************************************************************
  // Configuration registers
  // ************************************************************
  pcr_byte_t clkrx_r;
  pcr_byte_t pllen_r;
  pcr_byte_t loop_r;
  pcr_byte_t div_r;
  logic [1:0] evt_r;
  logic [1:0] irqen_r;
  logic [1:0] evt_nxt;
  logic [1:0] evt_set;
  logic [1:0] evt_clr;

  // Writable settings; read-only offsets have no branch here
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      clkrx_r <= `PCR_CLKRX_RST;
      pllen_r <= `PCR_PLLEN_RST;
      loop_r <= `PCR_LOOP_RST;
      div_r <= `PCR_DIV_RST;
      irqen_r <= 2'h0;
    end
    else if (wr_stb)
    begin
      case (paddr_in)
        `PCR_CLKRX_OFF: clkrx_r <= {pwdata_in[7:4], 4'h0};
        `PCR_PLLEN_OFF: pllen_r <= pwdata_in[7:0];
        `PCR_LOOP_OFF: loop_r <= {pwdata_in[7:6], 1'b0, pwdata_in[4:0]};
        `PCR_DIV_OFF: div_r <= {pwdata_in[7:6], 1'b0, pwdata_in[4:0]};
        `PCR_IRQEN_OFF: irqen_r <= pwdata_in[1:0];
        default: irqen_r <= irqen_r;
      endcase
    end
  end

  // ************************************************************
  // Event flags and interrupt
  // ************************************************************

  // A set in the same cycle as its clear survives
  always_comb
  begin
    evt_set = 2'h0;
    evt_set[`PCR_EV_LOST_BIT] = evt_bus.lock_lost;
    evt_set[`PCR_EV_GAINED_BIT] = evt_bus.lock_gained;
    evt_clr = (wr_stb && paddr_in == `PCR_EVCLR_OFF) ? pwdata_in[1:0] : 2'h0;
    evt_nxt = (evt_r & ~evt_clr) | evt_set;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      evt_r <= 2'h0;
    else
      evt_r <= evt_nxt;
  end

  assign irq_out = |(evt_r & irqen_r);

  // ************************************************************
  // Read path
  // ************************************************************
  logic [31:0] rdata_nxt;

  // Lock word comes straight from the analog side; band word is the band in use, the stored field when manual
  always_comb
  begin
    hit = 1'b1;
    rdata_nxt = 32'h0;
    case (paddr_in)
      `PCR_CLKRX_OFF: rdata_nxt[7:0] = clkrx_r;
      `PCR_PLLEN_OFF: rdata_nxt[7:0] = pllen_r;
      `PCR_LOOP_OFF: rdata_nxt[7:0] = loop_r;
      `PCR_DIV_OFF: rdata_nxt[7:0] = div_r;
      `PCR_LOCK_OFF: rdata_nxt[7:0] = {evt_bus.locked, 3'h0, vco_ctrl_voltage_in};
      `PCR_BAND_OFF: rdata_nxt[7:0] = {2'h0, vco_band_out};
      `PCR_EVT_OFF: rdata_nxt[1:0] = evt_r;
      `PCR_IRQEN_OFF: rdata_nxt[1:0] = irqen_r;
      `PCR_EVCLR_OFF: rdata_nxt = 32'h0;
      default: hit = 1'b0;
    endcase
  end

  // Zero-wait bus: read data is combinational in the access cycle
  assign prdata_out = rd_stb ? rdata_nxt : 32'h0;
  assign pslverr_out = psel_in & penable_in & ~hit;

  // ************************************************************
  // Control outputs
  // ************************************************************
  assign conv_duty_corr_out = clkrx_r[`PCR_CONV_DUTY_BIT];
  assign ref_duty_corr_out = clkrx_r[`PCR_REF_DUTY_BIT];
  assign conv_cross_corr_out = clkrx_r[`PCR_CONV_CROSS_BIT];
  assign ref_cross_corr_out = clkrx_r[`PCR_REF_CROSS_BIT];
  assign pll_on_out = pllen_r[`PCR_PLL_ON_BIT];
  assign manual_band_en_out = pllen_r[`PCR_MANUAL_BIT];
  // Band in use: manual field when manual, else the calibrated band
  assign vco_band_out = manual_band_en_out ? pllen_r[5:0] : auto_band_in;
  assign loop_bw_out = loop_r[7:6];
  assign charge_pump_out = loop_r[4:0];
  // The 75 MHz limit is software's duty; hardware does not clamp
  assign controller_clock_ratio_out = ctl_ratio(div_r[7:6]);
  assign xpt_ctrl_en_out = div_r[`PCR_XPT_BIT];
  assign vco_post_ratio_out = post_ratio(div_r[3:2]);
  assign loop_ratio_out = loop_ratio(div_r[1:0]);

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_rst_rel;
    $fell(rst_in);
  endsequence

  chk_reset_clkrx: assert property (@(posedge clk_in)
    s_rst_rel |-> conv_cross_corr_out && ref_cross_corr_out && !conv_duty_corr_out)
    else $error("clock receiver reset wrong");
  chk_reset_duty: assert property (@(posedge clk_in)
    s_rst_rel |-> !ref_duty_corr_out && !pll_on_out) else $error("duty or pll reset wrong");
  chk_reset_loop: assert property (@(posedge clk_in)
    s_rst_rel |-> loop_bw_out == 2'h3 && charge_pump_out == 5'h11)
    else $error("loop reset wrong");
  chk_reset_div: assert property (@(posedge clk_in) s_rst_rel |->
    controller_clock_ratio_out == 5'h10 && vco_post_ratio_out == 3'h4 && loop_ratio_out == 5'h04
    && xpt_ctrl_en_out) else $error("divider reset wrong");
  chk_manual_band: assert property (@(posedge clk_in) disable iff (rst_in)
    manual_band_en_out |-> vco_band_out == pllen_r[5:0]) else $error("manual band ignored");
  chk_pll_write: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_stb && paddr_in == `PCR_PLLEN_OFF |=> pll_on_out == $past(pwdata_in[7]))
    else $error("pll enable write lost");
  chk_lost_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    evt_bus.lock_lost |=> evt_r[`PCR_EV_LOST_BIT]) else $error("loss flag not set");
  chk_flag_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_stb && paddr_in == `PCR_EVCLR_OFF && pwdata_in[1] && !evt_bus.lock_lost
    |=> !evt_r[`PCR_EV_LOST_BIT]) else $error("flag not cleared");
  chk_lock_read: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_stb && paddr_in == `PCR_LOCK_OFF |-> prdata_out[7] == pll_locked_in
    && prdata_out[3:0] == vco_ctrl_voltage_in) else $error("lock status wrong");
  chk_ro_status: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_stb && (paddr_in == `PCR_LOCK_OFF || paddr_in == `PCR_BAND_OFF)
    |=> $stable(div_r) && $stable(pllen_r)) else $error("status write had effect");
endmodule

// ===== common/pcr_params.svh
// Register offsets, field positions and reset values for the clock receiver and PLL configuration
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH

// ************************************************************
// Register word indexes and byte addresses
// ************************************************************
`define PCR_CLKRX_IDX 8'h08
`define PCR_PLLEN_IDX 8'h0A
`define PCR_LOOP_IDX 8'h0C
`define PCR_DIV_IDX 8'h0D
`define PCR_LOCK_IDX 8'h0E
`define PCR_BAND_IDX 8'h0F
`define PCR_EVT_IDX 8'h10
`define PCR_IRQEN_IDX 8'h11
`define PCR_EVCLR_IDX 8'h12
`define PCR_CLKRX_OFF 12'h020
`define PCR_PLLEN_OFF 12'h028
`define PCR_LOOP_OFF 12'h030
`define PCR_DIV_OFF 12'h034
`define PCR_LOCK_OFF 12'h038
`define PCR_BAND_OFF 12'h03C
`define PCR_EVT_OFF 12'h040
`define PCR_IRQEN_OFF 12'h044
`define PCR_EVCLR_OFF 12'h048

// ************************************************************
// Reset values
// ************************************************************
`define PCR_CLKRX_RST 8'h30
`define PCR_PLLEN_RST 8'h40
`define PCR_LOOP_RST 8'hD1
`define PCR_DIV_RST 8'hD9

// ************************************************************
// Field positions
// ************************************************************
`define PCR_CONV_DUTY_BIT 7
`define PCR_REF_DUTY_BIT 6
`define PCR_CONV_CROSS_BIT 5
`define PCR_REF_CROSS_BIT 4
`define PCR_PLL_ON_BIT 7
`define PCR_MANUAL_BIT 6
`define PCR_XPT_BIT 4
`define PCR_LOCK_BIT 7
`define PCR_EV_LOST_BIT 1
`define PCR_EV_GAINED_BIT 0

`endif

// ===== common/pcr_pkg.sv
// Types shared by the clock receiver and PLL configuration block
package pcr_pkg;
  // APB access phase decode
  typedef enum logic [2:0]
  {
    PCR_IDLE = 3'b001,
    PCR_SETUP = 3'b010,
    PCR_ACCESS = 3'b100
  } pcr_apb_state_t;

  typedef logic [7:0] pcr_byte_t;
endpackage

// ===== common/pcr_evt_if.sv
// Event signals passed between the lock watcher and the register core
`timescale 1ns/1ns
interface pcr_evt_if;
  logic lock_lost;
  logic lock_gained;
  logic locked;

  modport src
  (
    output lock_lost,
    output lock_gained,
    output locked
  );
  modport dst
  (
    input lock_lost,
    input lock_gained,
    input locked
  );
endinterface

// ===== rtl/pcr_lock_watch.sv
// Lock edge watcher: raises one-cycle events on lock gained and lost
`timescale 1ns/1ns
module pcr_lock_watch
  import pcr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Analog lock level
  input wire logic pll_locked_in,
  // Events
  pcr_evt_if.src evt
);
  logic locked_r;
  logic ever_r;

  // Remember level and whether lock was ever reached
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      locked_r <= 1'b0;
      ever_r <= 1'b0;
    end
    else
    begin
      locked_r <= pll_locked_in;
      if (pll_locked_in)
        ever_r <= 1'b1;
    end
  end

  // Loss only counts after an earlier lock
  assign evt.lock_lost = locked_r & ~pll_locked_in & ever_r;
  assign evt.lock_gained = ~locked_r & pll_locked_in;
  assign evt.locked = pll_locked_in;

  chk_loss_needs_lock: assert property (@(posedge clk_in) disable iff (rst_in)
    evt.lock_lost |-> $past(pll_locked_in)) else $error("loss without prior lock");
endmodule

// ===== rtl/pcr_apb_slave.sv
// APB slave front end: decodes phase and produces write and read strobes
`timescale 1ns/1ns
module pcr_apb_slave
  import pcr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  // Strobes
  output logic wr_stb_out,
  output logic rd_stb_out,
  output logic pready_out
);
  pcr_apb_state_t st_r;

  // Track the protocol phase; no output or check reads it and penable is not examined
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      st_r <= PCR_IDLE;
    else
    begin
      case (st_r)
        PCR_IDLE: st_r <= psel_in ? PCR_SETUP : PCR_IDLE;
        PCR_SETUP: st_r <= PCR_ACCESS;
        PCR_ACCESS: st_r <= psel_in ? PCR_SETUP : PCR_IDLE;
        default: st_r <= PCR_IDLE;
      endcase
    end
  end

  // Zero wait states: every access completes in its first access cycle
  assign pready_out = 1'b1;
  assign wr_stb_out = psel_in & penable_in & pwrite_in;
  assign rd_stb_out = psel_in & penable_in & ~pwrite_in;
endmodule

// ===== sim/pcr_pll_model.sv
// Behavioural model of the analog PLL that feeds the status inputs
`timescale 1ns/1ns
module pcr_pll_model #(
  parameter logic [3:0] VOLT = 4'h9,
  parameter logic [5:0] BAND = 6'h2B
)
(
  // Clock
  input wire logic clk_in,
  // Controls
  input wire logic pll_on_in,
  input wire logic lock_req_in,
  // Status
  output logic locked_out,
  output logic [3:0] volt_out,
  output logic [5:0] band_out
);
  logic locked_r = 1'b0;
  // Lock only while the multiplier runs; a stopped loop cannot track
  always @(posedge clk_in)
  begin
    locked_r <= pll_on_in & lock_req_in;
  end
  assign locked_out = locked_r;
  assign volt_out = pll_on_in ? VOLT : 4'h0;
  assign band_out = BAND;
endmodule

// ===== sim/pcr_top_tb.sv
// Self-checking bench for the clock receiver and PLL register block
`timescale 1ns/1ns
`include "pcr_params.svh"
module pcr_top_tb;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clk_in, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lock_req = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, locked, irq;
  logic [3:0] volt;
  logic [5:0] aband;
  logic [32:0] outs;
  logic [31:0] ur;
  logic ue;
  int errors = 0;
  int compares = 0;
  logic [7:0] sh [4];
  localparam logic [11:0] ADR [4] = '{`PCR_CLKRX_OFF, `PCR_PLLEN_OFF, `PCR_LOOP_OFF, `PCR_DIV_OFF};
  localparam logic [7:0] RST [4] = '{`PCR_CLKRX_RST, `PCR_PLLEN_RST, `PCR_LOOP_RST, `PCR_DIV_RST};
  // Row: register index, write data, readback
  localparam logic [17:0] ROWS [10] = '{
    {2'd0, 8'hF0, 8'hF0}, {2'd0, 8'h0F, 8'h00}, {2'd1, 8'hBF, 8'hBF}, {2'd1, 8'h80, 8'h80},
    {2'd2, 8'h00, 8'h00}, {2'd2, 8'hFF, 8'hDF}, {2'd3, 8'h00, 8'h00}, {2'd3, 8'h55, 8'h55},
    {2'd3, 8'hAA, 8'h8A}, {2'd3, 8'hFF, 8'hDF}};

  pcr_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pll_locked_in(locked),
    .vco_ctrl_voltage_in(volt), .auto_band_in(aband),
    .conv_duty_corr_out(outs[32]), .ref_duty_corr_out(outs[31]),
    .conv_cross_corr_out(outs[30]), .ref_cross_corr_out(outs[29]), .pll_on_out(outs[28]),
    .manual_band_en_out(outs[27]), .vco_band_out(outs[26:21]), .loop_bw_out(outs[20:19]),
    .charge_pump_out(outs[18:14]), .controller_clock_ratio_out(outs[13:9]),
    .xpt_ctrl_en_out(outs[8]), .vco_post_ratio_out(outs[7:5]), .loop_ratio_out(outs[4:0]),
    .irq_out(irq));
  pcr_pll_model u_pll (.clk_in(clk_in), .pll_on_in(outs[28]), .lock_req_in(lock_req),
    .locked_out(locked), .volt_out(volt), .band_out(aband));

  // ************************************************************
  // Helpers
  // ************************************************************
  // Decode of the control fields, reckoned from the field tables
  function automatic logic [32:0] exp_outs(input logic [7:0] c, p, l, d);
    logic [4:0] r2;
    logic [2:0] r0;
    r2 = d[7] ? (d[6] ? 5'h10 : 5'h08) : 5'h02;
    r0 = d[3] ? 3'h4 : (d[2] ? 3'h2 : 3'h1);
    exp_outs = {c[7:4], p[7:6], p[6] ? p[5:0] : aband, l[7:6], l[4:0], r2, d[4], r0,
      5'h02 << d[1:0]};
  endfunction
  task automatic chk(input string nm, input logic [32:0] ex, got);
    compares++;
    if (got !== ex)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer; an idle cycle after it keeps drivers single per step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    // The wait for the answer ends once pready is seen high, else at the watchdog
    do
    begin
      @(posedge clk_in);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic er;
    apb(a, 1'b1, {24'h0, d}, rd, er);
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [7:0] ex);
    logic [31:0] rd;
    logic er;
    apb(a, 1'b0, 32'h0, rd, er);
    chk(nm, {25'h0, ex}, {1'b0, rd});
  endtask
  task automatic reset_chk();
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    for (int i = 0; i < 4; i++)
    begin
      sh[i] = RST[i];
      rdchk("reset value", ADR[i], RST[i]);
    end
    chk("reset outputs", exp_outs(sh[0], sh[1], sh[2], sh[3]), outs);
    chk("reset irq", 33'h0, {32'h0, irq});
    $display("Test reset done");
  endtask
  task automatic wrap_up();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ************************************************************
  // Clock, watchdog and tests
  // ************************************************************
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_in);
    errors++;
    $display("[FAIL] watchdog expected done seen hang");
    wrap_up();
  end
  initial
  begin
    reset_chk();
    foreach (ROWS[k])
    begin
      wr(ADR[ROWS[k][17:16]], ROWS[k][15:8]);
      rdchk("readback", ADR[ROWS[k][17:16]], ROWS[k][7:0]);
      sh[ROWS[k][17:16]] = ROWS[k][7:0];
      chk("outputs", exp_outs(sh[0], sh[1], sh[2], sh[3]), outs);
    end
    $display("Test field table done");
    wr(`PCR_IRQEN_OFF, 8'h03);
    rdchk("irq enable", `PCR_IRQEN_OFF, 8'h03);
    rdchk("no early flag", `PCR_EVT_OFF, 8'h00);
    lock_req <= 1'b1;
    repeat (4) @(posedge clk_in);
    rdchk("lock status", `PCR_LOCK_OFF, 8'h89);
    rdchk("band in use", `PCR_BAND_OFF, 8'h2B);
    rdchk("gained flag", `PCR_EVT_OFF, 8'h01);
    chk("irq raised", 33'h1, {32'h0, irq});
    wr(`PCR_EVCLR_OFF, 8'h01);
    rdchk("gained cleared", `PCR_EVT_OFF, 8'h00);
    chk("irq cleared", 33'h0, {32'h0, irq});
    wr(`PCR_IRQEN_OFF, 8'h02);
    lock_req <= 1'b0;
    repeat (4) @(posedge clk_in);
    rdchk("lost flag", `PCR_EVT_OFF, 8'h02);
    chk("irq lost", 33'h1, {32'h0, irq});
    wr(`PCR_IRQEN_OFF, 8'h00);
    chk("irq masked", 33'h0, {32'h0, irq});
    wr(`PCR_EVCLR_OFF, 8'h02);
    rdchk("lost cleared", `PCR_EVT_OFF, 8'h00);
    $display("Test events done");
    wr(`PCR_LOCK_OFF, 8'hFF);
    wr(`PCR_BAND_OFF, 8'hFF);
    rdchk("status kept", `PCR_LOCK_OFF, 8'h09);
    rdchk("band kept", `PCR_BAND_OFF, 8'h2B);
    apb(12'h07C, 1'b0, 32'h0, ur, ue);
    chk("unmapped error", 33'h1, {32'h0, ue});
    chk("unmapped read", 33'h0, {1'b0, ur});
    $display("Test read-only and unmapped done");
    wr(`PCR_CLKRX_OFF, 8'hF0);
    reset_chk();
    wrap_up();
  end
endmodule
